//--- hdl/omc_top.sv
/*
  operation mode controller: sleep / idle / active / limp home state machine,
  register reset control, write gating, limp home status overrides and the
  channel enable outputs.
  assumes the spi front end and the analog monitors sit outside and exchange
  plain level and pulse signals with this block on sys_clk.
*/
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - exactly four states: sleep, idle, active, limp
// - transitions use only pins and control bits
// - switch-on request wakes into active or limp
// - sleep: channels off, registers held reset
// - idle: channels off, no diagnosis
// - idle with logic supply: registers and spi work
// - idle never clears channel error bits
// - standby high plus request enters active
// - no request, keep-active low: back to idle
// - keep-active high holds active
// - logic undervoltage, inputs low: go idle
// - unrouted high input still enters active
// - standby low, input high: limp, routed channel on
// - limp: reads answered, writes ignored
// - limp: force supply flags, mode field 01
// - first command after limp: transfer error set
// - limp: open-load flags zero, others normal
// - limp: other registers held at default
// - limp: only channels 2 and 3 on
// - power-on from supply and pin levels
// - wake from idle delays turn-on by latency
// - soft reset, standby low, logic uv reset registers
module omc_top
  import omc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  standby_pin,
  input  wire logic [OMC_N_IN-1:0]   direct_input_pins,
  input  wire logic                  load_supply_ok,
  input  wire logic                  logic_supply_lowpower_ok,
  input  wire logic                  logic_supply_uv,
  input  wire logic                  spi_wr_req,
  input  wire logic [OMC_N_CH-1:0]   spi_wr_out_on,
  input  wire logic                  spi_wr_keep_active,
  input  wire logic                  spi_wr_pwm_a,
  input  wire logic                  spi_wr_pwm_b,
  input  wire logic [OMC_N_CH-1:0]   spi_wr_route_a,
  input  wire logic [OMC_N_CH-1:0]   spi_wr_route_b,
  input  wire logic                  spi_wr_soft_reset,
  input  wire logic                  spi_cmd_done,
  input  wire logic                  supply_uv_raw,
  input  wire logic                  logic_lp_raw,
  input  wire logic                  diag_clear,
  input  wire logic                  openload_on_raw,
  input  wire logic                  openload_off_raw,
  input  wire logic                  transfer_error_raw,
  input  wire logic [OMC_N_ERR-1:0]  channel_error_set,
  input  wire logic [OMC_N_ERR-1:0]  channel_error_clr,
  output logic      [1:0]            mode_field,
  output logic                       power_on,
  output logic      [OMC_N_CH-1:0]   channel_enable,
  output logic                       spi_enable,
  output logic                       spi_write_enable,
  output logic                       diag_enable,
  output logic                       regs_in_reset,
  output logic      [OMC_N_CH-1:0]   output_on_bits,
  output logic                       keep_active_bit,
  output logic                       pwm_gen_a_enable,
  output logic                       pwm_gen_b_enable,
  output logic      [OMC_N_CH-1:0]   input_a_route_reg,
  output logic      [OMC_N_CH-1:0]   input_b_route_reg,
  output logic                       supply_undervoltage_flag,
  output logic                       logic_low_power_flag,
  output logic                       transfer_error_flag,
  output logic                       openload_at_on_flag,
  output logic                       openload_at_off_flag,
  output logic      [OMC_N_ERR-1:0]  channel_error_bits
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [OMC_N_IN+3:0]  pins_s;
  logic                 stby_s;
  logic [OMC_N_IN-1:0]  din_s;
  logic                 lsok_s;
  logic                 llpok_s;
  logic                 luv_s;

  omc_sync #(.W(OMC_N_IN + 4)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({logic_supply_uv, logic_supply_lowpower_ok, load_supply_ok,
                standby_pin, direct_input_pins}),
    .sync_out (pins_s)
  );

  assign din_s   = pins_s[OMC_N_IN-1:0];
  assign stby_s  = pins_s[OMC_N_IN];
  assign lsok_s  = pins_s[OMC_N_IN+1];
  assign llpok_s = pins_s[OMC_N_IN+2];
  assign luv_s   = pins_s[OMC_N_IN+3];

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [OMC_N_CH-1:0] route_on(
    input logic [OMC_N_IN-1:0] din,
    input logic [OMC_N_CH-1:0] ra,
    input logic [OMC_N_CH-1:0] rb
  );
    route_on = ({OMC_N_CH{din[0]}} & ra) | ({OMC_N_CH{din[1]}} & rb);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode decision

  omc_state_t               state_r;
  omc_state_t               state_nxt;
  logic                     any_in;
  logic                     any_req;
  logic                     in_limp;
  logic                     reg_rst;
  logic                     wr_ok;
  logic [OMC_TRANS_W-1:0]   lat_cnt_r;
  logic                     lat_busy;

  assign any_in  = |din_s;
  assign any_req = any_in | (|output_on_bits) | pwm_gen_a_enable
                   | pwm_gen_b_enable;
  assign in_limp = (state_r == OMC_LIMP);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OMC_SLEEP: begin
        if (stby_s && !luv_s) begin
          state_nxt = OMC_IDLE;
        end
        if (!stby_s && any_in) begin
          state_nxt = OMC_LIMP;
        end else if (stby_s && any_in) begin
          state_nxt = OMC_ACTIVE;
        end
      end
      OMC_IDLE: begin
        if (!stby_s) begin
          state_nxt = any_in ? OMC_LIMP : OMC_SLEEP;
        end else if (any_req) begin
          state_nxt = OMC_ACTIVE;
        end
      end
      OMC_ACTIVE: begin
        if (!stby_s) begin
          state_nxt = any_in ? OMC_LIMP : OMC_SLEEP;
        end else if (luv_s && !any_in) begin
          state_nxt = OMC_IDLE;
        end else if (!keep_active_bit && !any_req) begin
          state_nxt = OMC_IDLE;
        end
        // keep-active set holds active while standby stays high and logic undervoltage is absent
      end
      OMC_LIMP: begin
        if (stby_s) begin
          state_nxt = any_req ? OMC_ACTIVE : OMC_IDLE;
        end else if (!any_in) begin
          state_nxt = OMC_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= OMC_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // turn-on waits out the latency when leaving sleep or idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lat_cnt_r <= '0;
    end else if ((state_r == OMC_SLEEP || state_r == OMC_IDLE)
                 && (state_nxt == OMC_ACTIVE || state_nxt == OMC_LIMP)) begin
      lat_cnt_r <= OMC_TRANS_W'(OMC_TRANS_CYC);
    end else if (lat_cnt_r != '0) begin
      lat_cnt_r <= lat_cnt_r - 1'b1;
    end
  end

  assign lat_busy = (lat_cnt_r != '0);

  //////////////////////////////////////////////////////////////////////////////
  // register reset and write gating

  // sleep, standby low, logic uv or soft reset return registers to default
  assign reg_rst = (state_r == OMC_SLEEP) || !stby_s || luv_s
                   || (spi_wr_req && spi_wr_soft_reset);
  // writes only in idle/active; limp home is read-only
  assign wr_ok   = spi_wr_req && !in_limp && !reg_rst
                   && (state_r != OMC_SLEEP);

  always_ff @(posedge sys_clk) begin
    if (rst || reg_rst || in_limp) begin
      output_on_bits    <= OMC_OUT_RST;
      keep_active_bit   <= 1'b0;
      pwm_gen_a_enable  <= 1'b0;
      pwm_gen_b_enable  <= 1'b0;
      input_a_route_reg <= OMC_ROUTE_A_RST;
      input_b_route_reg <= OMC_ROUTE_B_RST;
    end else if (wr_ok) begin
      output_on_bits    <= spi_wr_out_on;
      keep_active_bit   <= spi_wr_keep_active;
      pwm_gen_a_enable  <= spi_wr_pwm_a;
      pwm_gen_b_enable  <= spi_wr_pwm_b;
      input_a_route_reg <= spi_wr_route_a;
      input_b_route_reg <= spi_wr_route_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags

  // error bits survive every register reset; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_error_bits <= '0;
    end else begin
      channel_error_bits <= (channel_error_bits & ~channel_error_clr)
                            | channel_error_set;
    end
  end

  // supply flags: raw level sets, readout clears, reset clears
  always_ff @(posedge sys_clk) begin
    if (rst || (reg_rst && !in_limp)) begin
      supply_undervoltage_flag <= 1'b0;
      logic_low_power_flag     <= 1'b0;
    end else if (in_limp) begin
      supply_undervoltage_flag <= 1'b1;
      logic_low_power_flag     <= 1'b1;
    end else begin
      supply_undervoltage_flag <= supply_uv_raw
                                  | (supply_undervoltage_flag & ~diag_clear);
      logic_low_power_flag     <= logic_lp_raw
                                  | (logic_low_power_flag & ~diag_clear);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || reg_rst || in_limp || state_r != OMC_ACTIVE) begin
      openload_at_on_flag  <= 1'b0;
      openload_at_off_flag <= 1'b0;
    end else begin
      openload_at_on_flag  <= openload_on_raw
                              | (openload_at_on_flag & ~diag_clear);
      openload_at_off_flag <= openload_off_raw
                              | (openload_at_off_flag & ~diag_clear);
    end
  end

  // first command after limp entry reports a transfer error
  logic limp_first_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      limp_first_r <= 1'b0;
    end else if (!in_limp && state_nxt == OMC_LIMP) begin
      limp_first_r <= 1'b1;
    end else if (spi_cmd_done || !in_limp) begin
      limp_first_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      transfer_error_flag <= 1'b0;
    end else if (in_limp && limp_first_r) begin
      transfer_error_flag <= 1'b1;
    end else begin
      transfer_error_flag <= transfer_error_raw;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode outputs

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_field <= OMC_FIELD_SLEEP;
    end else begin
      unique case (state_r)
        OMC_SLEEP:  mode_field <= OMC_FIELD_SLEEP;
        OMC_IDLE:   mode_field <= OMC_FIELD_IDLE;
        OMC_ACTIVE: mode_field <= OMC_FIELD_ACTIVE;
        OMC_LIMP:   mode_field <= OMC_FIELD_LIMP;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_on <= 1'b0;
    end else begin
      power_on <= (lsok_s || llpok_s) && (any_in || stby_s);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_enable <= '0;
    end else if (lat_busy) begin
      channel_enable <= '0;
    end else begin
      unique case (state_r)
        OMC_ACTIVE: channel_enable <= output_on_bits
                      | route_on(din_s, input_a_route_reg, input_b_route_reg);
        OMC_LIMP:   channel_enable <= OMC_LIMP_CH_MASK
                      & route_on(din_s, OMC_ROUTE_A_RST, OMC_ROUTE_B_RST);
        default:    channel_enable <= '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_enable       <= 1'b0;
      spi_write_enable <= 1'b0;
      diag_enable      <= 1'b0;
      regs_in_reset    <= 1'b1;
    end else begin
      spi_enable       <= (state_r != OMC_SLEEP) && !luv_s;
      spi_write_enable <= (state_r == OMC_IDLE || state_r == OMC_ACTIVE) && !luv_s;
      diag_enable      <= (state_r == OMC_ACTIVE);
      regs_in_reset    <= reg_rst;
    end
  end

endmodule

//--- pkg/omc_pkg.sv
/*
  package of the operation mode controller: state codes, status field values,
  channel layout and transition latency.
  assumes a 25 MHz system clock.
*/
package omc_pkg;

  localparam int unsigned  OMC_CLK_HZ        = 25_000_000;
  localparam int unsigned  OMC_N_CH          = 8;
  localparam int unsigned  OMC_N_IN          = 2;
  localparam int unsigned  OMC_N_ERR         = 8;

  // mode transition latency, in ns, and the derived cycle count (round up)
  localparam int unsigned  OMC_TRANS_NS      = 200;
  localparam int unsigned  OMC_TRANS_CYC     = (OMC_TRANS_NS * (OMC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned  OMC_TRANS_W       = 8;

  // reported mode field values
  localparam logic [1:0]   OMC_FIELD_SLEEP   = 2'h0;
  localparam logic [1:0]   OMC_FIELD_LIMP    = 2'h1;
  localparam logic [1:0]   OMC_FIELD_ACTIVE  = 2'h2;
  localparam logic [1:0]   OMC_FIELD_IDLE    = 2'h3;

  // channels that direct inputs may drive in limp home
  localparam int unsigned  OMC_LIMP_CH_A     = 2;
  localparam int unsigned  OMC_LIMP_CH_B     = 3;
  localparam logic [7:0]   OMC_LIMP_CH_MASK  = 8'h0C;

  // default route of each direct input
  localparam logic [7:0]   OMC_ROUTE_A_RST   = 8'h04;
  localparam logic [7:0]   OMC_ROUTE_B_RST   = 8'h08;
  localparam logic [7:0]   OMC_OUT_RST       = 8'h00;

  typedef enum logic [1:0] {
    OMC_SLEEP  = 2'b00,
    OMC_IDLE   = 2'b01,
    OMC_ACTIVE = 2'b10,
    OMC_LIMP   = 2'b11
  } omc_state_t;

endpackage

//--- hdl/omc_sync.sv
/*
  two-flop synchroniser for a bundle of level inputs.
  assumes inputs are quasi-static levels from pins.
*/
`timescale 1ns/1ps
module omc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  async_in,
  output logic      [W-1:0]  sync_out
);

  logic [W-1:0]  meta_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- bench/omc_top_sva.sv
/*
  concurrent checks on the mode controller ports.
  assumes sys_clk domain only, bound into every omc_top.
*/
`timescale 1ns/1ps
module omc_top_sva
  import omc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       standby_pin,
  input wire logic [1:0] direct_input_pins,
  input wire logic       logic_supply_uv,
  input wire logic       spi_wr_req,
  input wire logic [7:0] channel_error_clr,
  input wire logic [1:0] mode_field,
  input wire logic [7:0] channel_enable,
  input wire logic       diag_enable,
  input wire logic       spi_write_enable,
  input wire logic [7:0] output_on_bits,
  input wire logic       keep_active_bit,
  input wire logic       pwm_gen_a_enable,
  input wire logic       pwm_gen_b_enable,
  input wire logic [7:0] input_a_route_reg,
  input wire logic       supply_undervoltage_flag,
  input wire logic       logic_low_power_flag,
  input wire logic       openload_at_on_flag,
  input wire logic       openload_at_off_flag,
  input wire logic [7:0] channel_error_bits
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // pins pass a two-flop synchroniser, so pin antecedents hold for several cycles
  wire req = |output_on_bits | keep_active_bit | pwm_gen_a_enable | pwm_gen_b_enable;
  wire limp2 = mode_field == OMC_FIELD_LIMP;
  ////////////////////////////////////////
  sleep_all_off_a: assert property (
    mode_field == OMC_FIELD_SLEEP |-> channel_enable == 8'h00 && output_on_bits == 8'h00)
    else $error("channel or register live in sleep");
  idle_no_drive_a: assert property (
    mode_field == OMC_FIELD_IDLE |-> channel_enable == 8'h00 && !diag_enable)
    else $error("channel or diagnosis live in idle");
  idle_keeps_err_a: assert property (
    mode_field == OMC_FIELD_IDLE && channel_error_clr == 8'h00 |=>
    (channel_error_bits & $past(channel_error_bits)) == $past(channel_error_bits))
    else $error("error bit lost in idle");
  enter_active_a: assert property (
    (standby_pin && |direct_input_pins)[*4] |-> ##[0:4] mode_field == OMC_FIELD_ACTIVE)
    else $error("no active entry on input");
  enter_limp_a: assert property (
    (!standby_pin && |direct_input_pins)[*4] |-> ##[0:4] limp2)
    else $error("no limp entry");
  limp_ch_mask_a: assert property (
    limp2 |-> (channel_enable & ~OMC_LIMP_CH_MASK) == 8'h00)
    else $error("forbidden channel on in limp");
  limp_forced_a: assert property (
    limp2 && $past(limp2) |-> supply_undervoltage_flag && logic_low_power_flag
    && !openload_at_on_flag && !openload_at_off_flag)
    else $error("limp flags not forced");
  limp_locked_a: assert property (
    limp2 && $past(limp2) |-> !spi_write_enable && output_on_bits == 8'h00
    && !keep_active_bit && input_a_route_reg == OMC_ROUTE_A_RST)
    else $error("register writable in limp");
  wake_delay_a: assert property (
    $past(mode_field) == OMC_FIELD_IDLE && mode_field == OMC_FIELD_ACTIVE
    |-> (channel_enable == 8'h00)[*5])
    else $error("turn-on without latency");
  stay_active_a: assert property (
    (standby_pin && !logic_supply_uv && !spi_wr_req)[*4] ##0
    (mode_field == OMC_FIELD_ACTIVE && keep_active_bit) |=> mode_field == OMC_FIELD_ACTIVE)
    else $error("left active with keep-active set");
  back_idle_a: assert property (
    (standby_pin && direct_input_pins == 2'h0 && !spi_wr_req && !req)[*6]
    |-> ##[0:3] mode_field != OMC_FIELD_ACTIVE)
    else $error("stuck in active without request");
endmodule

bind omc_top omc_top_sva chk (.sys_clk, .rst, .standby_pin, .direct_input_pins,
  .logic_supply_uv, .spi_wr_req, .channel_error_clr, .mode_field, .channel_enable,
  .diag_enable, .spi_write_enable, .output_on_bits, .keep_active_bit, .pwm_gen_a_enable,
  .pwm_gen_b_enable, .input_a_route_reg, .supply_undervoltage_flag, .logic_low_power_flag,
  .openload_at_on_flag, .openload_at_off_flag, .channel_error_bits);

//--- bench/omc_host_model.sv
/*
  host model: standby and direct input pins, spi write word and command strobe.
  assumes the bench calls its tasks; changes come 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module omc_host_model (
  input  wire logic       sys_clk,
  output logic            standby_pin,
  output logic [1:0]      direct_input_pins,
  output logic            spi_wr_req,
  output logic [7:0]      spi_wr_out_on,
  output logic            spi_wr_keep_active,
  output logic            spi_wr_pwm_a,
  output logic            spi_wr_pwm_b,
  output logic [7:0]      spi_wr_route_a,
  output logic [7:0]      spi_wr_route_b,
  output logic            spi_wr_soft_reset,
  output logic            spi_cmd_done
);
  logic [27:0] w;
  assign {spi_wr_out_on, spi_wr_keep_active, spi_wr_pwm_a, spi_wr_pwm_b, spi_wr_route_a,
          spi_wr_route_b, spi_wr_soft_reset} = w;
  initial begin
    {standby_pin, direct_input_pins, spi_wr_req, spi_cmd_done} = '0;
    w = '0;
  end
  ////////////////////////////////////////
  task automatic pins(input logic s, input logic [1:0] d);
    @(posedge sys_clk);
    #1;
    standby_pin = s;
    direct_input_pins = d;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [27:0] v);
    @(posedge sys_clk);
    #1;
    w = v;
    spi_wr_req = 1'b1;
    @(posedge sys_clk);
    #1;
    spi_wr_req = 1'b0;
    spi_cmd_done = 1'b1;
    // word is stale once the strobe drops: show its inverse, never the old value
    w = ~v;
    @(posedge sys_clk);
    #1;
    spi_cmd_done = 1'b0;
  endtask
endmodule

//--- bench/omc_top_tb.sv
/*
  self-checking bench of omc_top against a mode model kept in the bench.
  assumes omc_pkg, omc_top and the host model are compiled first.
*/
`timescale 1ns/1ps
module omc_top_tb;
  import omc_pkg::*;
  logic        sys_clk = 0, rst = 1, logic_supply_uv = 0, en = 0, cur_s = 0;
  logic        supply_uv_raw = 0, logic_lp_raw = 0, diag_clear = 0, openload_on_raw = 0;
  logic        openload_off_raw = 0, transfer_error_raw = 0, logic_supply_lowpower_ok = 0;
  logic        load_supply_ok = 1, lp_fix = 0, te_q = 0, keep_active_bit, regs_in_reset;
  logic        pwm_gen_a_enable, pwm_gen_b_enable;
  logic [7:0]  channel_error_set = 0, channel_error_clr = 0, m_err = 0;
  logic [7:0]  m_out, m_ra, m_rb;
  logic        m_ka, m_pa, m_pb;
  logic [1:0]  cur_d = 0, e_mode = OMC_FIELD_SLEEP;
  logic [31:0] rng = 32'h0000C37F;
  int          n_errors = 0, n_compared = 0;
  logic        standby_pin, spi_wr_req, spi_wr_keep_active, spi_wr_pwm_a, spi_wr_pwm_b;
  logic        spi_wr_soft_reset, spi_cmd_done, power_on, spi_enable, transfer_error_flag;
  logic [1:0]  direct_input_pins, mode_field;
  logic [7:0]  spi_wr_out_on, spi_wr_route_a, spi_wr_route_b, channel_enable;
  logic [7:0]  output_on_bits, input_a_route_reg, input_b_route_reg, channel_error_bits;
  always #20 sys_clk = ~sys_clk;
  omc_host_model host (.sys_clk, .standby_pin, .direct_input_pins, .spi_wr_req,
    .spi_wr_out_on, .spi_wr_keep_active, .spi_wr_pwm_a, .spi_wr_pwm_b, .spi_wr_route_a,
    .spi_wr_route_b, .spi_wr_soft_reset, .spi_cmd_done);
  omc_top uut (.sys_clk, .rst, .standby_pin, .direct_input_pins, .load_supply_ok,
    .logic_supply_lowpower_ok, .logic_supply_uv, .spi_wr_req, .spi_wr_out_on,
    .spi_wr_keep_active, .spi_wr_pwm_a, .spi_wr_pwm_b, .spi_wr_route_a, .spi_wr_route_b,
    .spi_wr_soft_reset, .spi_cmd_done, .supply_uv_raw, .logic_lp_raw, .diag_clear,
    .openload_on_raw, .openload_off_raw, .transfer_error_raw, .channel_error_set,
    .channel_error_clr, .mode_field, .power_on, .channel_enable, .spi_enable,
    .spi_write_enable(), .diag_enable(), .regs_in_reset, .output_on_bits,
    .keep_active_bit, .pwm_gen_a_enable, .pwm_gen_b_enable, .input_a_route_reg,
    .input_b_route_reg, .supply_undervoltage_flag(), .logic_low_power_flag(),
    .transfer_error_flag, .openload_at_on_flag(), .openload_at_off_flag(),
    .channel_error_bits);
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // error set/clear and diag clear stay quiet outside en, so latched flags hold
  always @(posedge sys_clk) begin
    #1;
    // level that the design took at this edge
    te_q = transfer_error_raw;
    rng = lfsr(rng);
    {supply_uv_raw, logic_lp_raw, openload_on_raw, openload_off_raw} = rng[3:0];
    // low-power level is random only while the load supply is good
    {transfer_error_raw, logic_supply_lowpower_ok} = {rng[5], load_supply_ok ? rng[4] : lp_fix};
    diag_clear = en & rng[6];
    channel_error_set = en ? rng[15:8] & rng[23:16] : 8'h00;
    channel_error_clr = en ? rng[31:24] : 8'h00;
    m_err = (m_err & ~channel_error_clr) | channel_error_set;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rst_m();
    {m_out, m_ka, m_pa, m_pb, m_ra, m_rb} = {8'h00, 3'h0, OMC_ROUTE_A_RST, OMC_ROUTE_B_RST};
  endtask
  function automatic logic [1:0] mdl();
    if (!cur_s) return (cur_d != 0) ? OMC_FIELD_LIMP : OMC_FIELD_SLEEP;
    if (cur_d != 0 || m_out != 0 || m_pa || m_pb || (m_ka && e_mode == OMC_FIELD_ACTIVE))
      return OMC_FIELD_ACTIVE;
    return OMC_FIELD_IDLE;
  endfunction
  task automatic cmp_all();
    logic [7:0] ch, ex;
    // outputs launch on the edge; look once they have settled
    #2;
    ch = (cur_d[0] ? m_ra : 8'h00) | (cur_d[1] ? m_rb : 8'h00);
    if (e_mode == OMC_FIELD_LIMP) ch = ch & OMC_LIMP_CH_MASK;
    else if (e_mode == OMC_FIELD_ACTIVE) ch = ch | m_out;
    else ch = 8'h00;
    chk("mode_field", e_mode, mode_field);
    chk("channel_enable", ch, channel_enable);
    chk("output_on_bits", m_out, output_on_bits);
    chk("input_b_route_reg", m_rb, input_b_route_reg);
    chk("channel_error_bits", m_err, channel_error_bits);
    chk("input_a_route_reg", m_ra, input_a_route_reg);
    chk("keep_active_bit", {7'h00, m_ka}, {7'h00, keep_active_bit});
    chk("pwm_en", {6'h00, m_pa, m_pb}, {6'h00, pwm_gen_a_enable, pwm_gen_b_enable});
    chk("regs_in_reset", {7'h00, !cur_s | logic_supply_uv}, {7'h00, regs_in_reset});
    ex = {7'h00, e_mode != OMC_FIELD_SLEEP && !logic_supply_uv};
    chk("spi_enable", ex, {7'h00, spi_enable});
    ex = {7'h00, (load_supply_ok | lp_fix) & (cur_s | (|cur_d))};
    chk("power_on", ex, {7'h00, power_on});
  endtask
  task automatic pin(input logic s, input logic [1:0] d);
    host.pins(s, d);
    {cur_s, cur_d} = {s, d};
    if (!s) rst_m();
    e_mode = mdl();
    cmp_all();
  endtask
  task automatic wr(input logic [7:0] o, input logic [2:0] kab, input logic [7:0] ra, rb,
                    input logic sr);
    logic ok;
    ok = (e_mode == OMC_FIELD_IDLE || e_mode == OMC_FIELD_ACTIVE) && cur_s && !logic_supply_uv;
    host.wr({o, kab, ra, rb, sr});
    repeat (10) @(posedge sys_clk);
    if (ok && sr) rst_m();
    else if (ok) {m_out, m_ka, m_pa, m_pb, m_ra, m_rb} = {o, kab, ra, rb};
    e_mode = mdl();
    cmp_all();
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    rst_m();
    repeat (16) @(posedge sys_clk);
    #1 rst = 0;
    repeat (3) @(posedge sys_clk);
    cmp_all();
    pin(1'b1, 2'h0);
    chk("spi_enable", 8'h01, {7'h00, spi_enable});
    en = 1;
    repeat (24) @(posedge sys_clk);
    en = 0;
    repeat (3) @(posedge sys_clk);
    cmp_all();
    wr(8'h01, 3'h0, OMC_ROUTE_A_RST, OMC_ROUTE_B_RST, 1'b0);
    wr(8'h00, 3'h4, OMC_ROUTE_A_RST, OMC_ROUTE_B_RST, 1'b0);
    wr(8'h00, 3'h0, OMC_ROUTE_A_RST, OMC_ROUTE_B_RST, 1'b0);
    for (int i = 1; i <= 2; i++) begin
      wr(8'h00, 3'(i), 8'h00, 8'h00, 1'b0);
    end
    wr(8'h00, 3'h0, 8'h00, 8'h00, 1'b0);
    pin(1'b1, 2'h1);
    pin(1'b1, 2'h0);
    wr(8'h81, 3'h0, 8'h10, 8'h20, 1'b0);
    wr(8'h81, 3'h0, 8'h10, 8'h20, 1'b1);
    wr(8'h02, 3'h0, 8'h04, 8'h08, 1'b0);
    @(posedge sys_clk);
    #1 logic_supply_uv = 1;
    repeat (12) @(posedge sys_clk);
    rst_m();
    e_mode = mdl();
    cmp_all();
    @(posedge sys_clk);
    #1 logic_supply_uv = 0;
    repeat (12) @(posedge sys_clk);
    pin(1'b0, 2'h2);
    chk("transfer_error_flag", 8'h01, {7'h00, transfer_error_flag});
    wr(8'hFF, 3'h7, 8'hFF, 8'hFF, 1'b0);
    // after the first command the flag follows the raw level again
    chk("transfer_error_flag", {7'h00, te_q}, {7'h00, transfer_error_flag});
    pin(1'b0, 2'h3);
    pin(1'b1, 2'h0);
    @(posedge sys_clk);
    #1 load_supply_ok = 0;
    lp_fix = 1;
    repeat (6) @(posedge sys_clk);
    cmp_all();
    lp_fix = 0;
    repeat (6) @(posedge sys_clk);
    cmp_all();
    summarize();
  end
endmodule
